/* File: core/fftpp_core.sv */
// Memory sequencing of the ping-pong FFT engine: bank swap, strobes, result order.
// Assumes the butterfly datapath is outside; result samples come from result_in.
//
// The implementer's own choices: the placing of the registers and the registered result port.
`timescale 1ns/1ps
module fftpp_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration
  input wire fftpp_pkg::fftpp_arr_t arrangement,
  // Datapath result feed, digit-reversed order
  input wire logic [fftpp_pkg::DW-1:0] result_in_re,
  input wire logic [fftpp_pkg::DW-1:0] result_in_im,
  // Latched mode for the datapath
  output logic cur_direction,
  output logic [1:0] cur_scale,
  // Link to host
  fftpp_if.core lnk
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fftpp_pkg::fftpp_state_t st;
    logic [fftpp_pkg::AW-1:0] ld_addr;
    logic [12:0] cyc;
    logic first;
    logic bank;
    logic dir;
    logic [1:0] scale;
    logic rvalid;
    logic done;
    logic [fftpp_pkg::AW-1:0] oaddr;
    logic [fftpp_pkg::DW-1:0] rre;
    logic [fftpp_pkg::DW-1:0] rim;
  } fftpp_core_t;

  fftpp_core_t r;
  fftpp_core_t next_r;
  logic [12:0] period;
  logic [12:0] res_start;
  logic [12:0] rel;
  logic loading;
  logic running;

  // ----------------------------------------------------------------
  // Transform timing
  // ----------------------------------------------------------------
  // Length in cycles of the transform in progress; the opening dual
  // transform is shorter because no earlier vector overlaps it
  function automatic logic [12:0] span(input logic first, input fftpp_pkg::fftpp_arr_t arr);
    logic [12:0] s;
    if (first && arr == fftpp_pkg::DUAL) begin
      s = fftpp_pkg::DUAL_FIRST_DONE;
    end else if (arr == fftpp_pkg::DUAL) begin
      s = fftpp_pkg::DUAL_PERIOD;
    end else begin
      s = fftpp_pkg::TRIPLE_PERIOD;
    end
    return s;
  endfunction

  // Result window ends the cycle before done, so the last sample is out
  // before the banks swap and the host port moves onto the finished bank
  always_comb begin
    period = span(r.first, arrangement);
    res_start = period - fftpp_pkg::RESULT_LEN - fftpp_pkg::ONE;
    rel = r.cyc - res_start;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      fftpp_pkg::IDLE: begin
        if (lnk.load_request) begin
          next_r.st = fftpp_pkg::LOAD;
          next_r.ld_addr = '0;
        end else if (lnk.start) begin
          next_r.st = fftpp_pkg::RUN;
          next_r.cyc = '0;
          next_r.first = 1'b1;
          next_r.dir = lnk.transform_direction;
          next_r.scale = lnk.scale_select;
          next_r.bank = 1'b1;
        end
      end
      fftpp_pkg::LOAD: begin
        next_r.ld_addr = r.ld_addr + 1'b1;
        if (r.ld_addr == fftpp_pkg::LAST_ADDR) begin
          next_r.st = fftpp_pkg::IDLE;
        end
      end
      fftpp_pkg::RUN: begin
        if (lnk.start) begin
          // Restart the whole engine
          next_r.cyc = '0;
          next_r.first = 1'b1;
          next_r.bank = 1'b1;
          next_r.dir = lnk.transform_direction;
          next_r.scale = lnk.scale_select;
        end else begin
          next_r.cyc = r.cyc + fftpp_pkg::ONE;
          if (r.cyc == fftpp_pkg::MODE_SAMPLE_AT && !r.first) begin
            next_r.dir = lnk.transform_direction;
            next_r.scale = lnk.scale_select;
          end
          // Period already covers the short opening dual transform
          if (r.cyc == period - fftpp_pkg::ONE) begin
            next_r.cyc = '0;
            next_r.first = 1'b0;
            next_r.done = 1'b1;
            if (arrangement == fftpp_pkg::TRIPLE) begin
              next_r.bank = ~r.bank;
            end
          end
        end
      end
      default: next_r.st = fftpp_pkg::IDLE;
    endcase
    // Result window at the tail of each transform
    next_r.rvalid = 1'b0;
    next_r.oaddr = '0;
    if (r.st == fftpp_pkg::RUN && !lnk.start && rel < fftpp_pkg::RESULT_LEN) begin
      next_r.rvalid = 1'b1;
      next_r.oaddr = fftpp_pkg::digit_rev(rel[fftpp_pkg::AW-1:0]);
      next_r.rre = result_in_re;
      next_r.rim = result_in_im;
    end
    if (!rst_n) begin
      next_r = '0;
    end
  end

  // Registered state with clock enable
  always_ff @(posedge clk) begin
    if (ce || !rst_n) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Core owns one input bank, the host the other; results go to output bank only
  assign loading = (r.st == fftpp_pkg::LOAD);
  assign running = (r.st == fftpp_pkg::RUN);
  assign lnk.bank_select = r.bank;
  assign lnk.mode_sample = running && !r.first && r.cyc == fftpp_pkg::MODE_SAMPLE_AT;
  assign lnk.result_valid = r.rvalid;
  assign lnk.done = r.done;
  assign lnk.order_addr = r.oaddr;
  assign lnk.result_sample_re = r.rre;
  assign lnk.result_sample_im = r.rim;
  assign lnk.load_addr = r.ld_addr;
  // Port A is the host write port, port B the engine working port
  assign lnk.first_bank_port_a_write_en = loading || (running && !r.bank);
  assign lnk.second_bank_port_a_write_en = running && r.bank;
  assign lnk.first_bank_port_b_write_en = running && r.bank;
  assign lnk.second_bank_port_b_write_en = running && !r.bank;
  assign lnk.first_bank_port_a_enable = lnk.first_bank_port_a_write_en;
  assign lnk.second_bank_port_a_enable = lnk.second_bank_port_a_write_en;
  assign cur_direction = r.dir;
  assign cur_scale = r.scale;
endmodule

/* File: core/fftpp_host.sv */
// Host end: fills the first bank, starts the engine, streams samples, sets mode.
// Assumes the input multiplexer and memories sit outside, steered by bank_select.
`timescale 1ns/1ps
module fftpp_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // User side
  input wire logic go,
  input wire logic user_direction,
  input wire logic [1:0] user_scale,
  input wire logic [fftpp_pkg::DW-1:0] user_re,
  input wire logic [fftpp_pkg::DW-1:0] user_im,
  output logic sample_take,
  output logic vector_ready,
  // Link to core
  fftpp_if.host lnk
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fftpp_pkg::fftpp_hstate_t st;
    logic [fftpp_pkg::AW:0] cnt;
    logic [1:0] pace;
    logic load;
    logic start;
    logic [fftpp_pkg::DW-1:0] re;
    logic [fftpp_pkg::DW-1:0] im;
    logic ready;
  } fftpp_host_t;

  fftpp_host_t r;
  fftpp_host_t next_r;

  // Next state
  always_comb begin
    next_r = r;
    next_r.load = 1'b0;
    next_r.start = 1'b0;
    next_r.ready = lnk.done;
    case (r.st)
      fftpp_pkg::H_IDLE: begin
        if (go) begin
          next_r.load = 1'b1;
          next_r.cnt = '0;
          next_r.st = fftpp_pkg::H_FILL;
        end
      end
      fftpp_pkg::H_FILL: begin
        // Start waits one cycle past the last sample: the core ignores it while loading
        if (r.cnt[fftpp_pkg::AW]) begin
          next_r.start = 1'b1;
          next_r.pace = '0;
          next_r.st = fftpp_pkg::H_STREAM;
        end else begin
          next_r.re = user_re;
          next_r.im = user_im;
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      fftpp_pkg::H_STREAM: begin
        next_r.pace = r.pace + 1'b1;
        if (r.pace == fftpp_pkg::SAMPLE_SPACING) begin
          next_r.re = user_re;
          next_r.im = user_im;
        end
      end
      default: next_r.st = fftpp_pkg::H_IDLE;
    endcase
    if (!rst_n) begin
      next_r = '0;
    end
  end

  // Registered state with clock enable
  always_ff @(posedge clk) begin
    if (ce || !rst_n) begin
      r <= next_r;
    end
  end

  // Outputs
  assign lnk.load_request = r.load;
  assign lnk.start = r.start;
  assign lnk.unload_request = 1'b0;
  assign lnk.transform_direction = user_direction;
  assign lnk.scale_select = user_scale;
  assign lnk.input_sample_re = r.re;
  assign lnk.input_sample_im = r.im;
  assign sample_take = (r.st == fftpp_pkg::H_FILL && !r.cnt[fftpp_pkg::AW]) ||
                       (r.st == fftpp_pkg::H_STREAM && r.pace == fftpp_pkg::SAMPLE_SPACING);
  assign vector_ready = r.ready;
endmodule

/* File: inc/fftpp_if.sv */
// Link between the ping-pong FFT memory controller and the host logic.
// Assumes both ends share one clock; no clocking block.
`timescale 1ns/1ps
interface fftpp_if;
  // Host to core
  logic load_request;
  logic start;
  logic unload_request;
  logic transform_direction;
  logic [1:0] scale_select;
  logic [fftpp_pkg::DW-1:0] input_sample_re;
  logic [fftpp_pkg::DW-1:0] input_sample_im;
  // Core to host
  logic bank_select;
  logic mode_sample;
  logic result_valid;
  logic done;
  logic [fftpp_pkg::AW-1:0] order_addr;
  logic [fftpp_pkg::DW-1:0] result_sample_re;
  logic [fftpp_pkg::DW-1:0] result_sample_im;
  logic [fftpp_pkg::AW-1:0] load_addr;
  logic first_bank_port_a_write_en;
  logic second_bank_port_a_write_en;
  logic first_bank_port_b_write_en;
  logic second_bank_port_b_write_en;
  logic first_bank_port_a_enable;
  logic second_bank_port_a_enable;

  modport core (
    input load_request, start, unload_request, transform_direction, scale_select,
    input input_sample_re, input_sample_im,
    output bank_select, mode_sample, result_valid, done, order_addr,
    output result_sample_re, result_sample_im, load_addr,
    output first_bank_port_a_write_en, second_bank_port_a_write_en,
    output first_bank_port_b_write_en, second_bank_port_b_write_en,
    output first_bank_port_a_enable, second_bank_port_a_enable
  );
  modport host (
    output load_request, start, unload_request, transform_direction, scale_select,
    output input_sample_re, input_sample_im,
    input bank_select, mode_sample, result_valid, done, order_addr,
    input result_sample_re, result_sample_im, load_addr,
    input first_bank_port_a_write_en, second_bank_port_a_write_en,
    input first_bank_port_b_write_en, second_bank_port_b_write_en,
    input first_bank_port_a_enable, second_bank_port_a_enable
  );
endinterface

/* File: inc/fftpp_pkg.sv */
// Constants shared by the ping-pong FFT memory controller and its host end.
// Assumes one 250 MHz clock for both ends and no register bus.
// Functional notes
// - Dual arrangement: new result every 5120 cycles
// - Dual arrangement: first done 4144 after start
// - Two input banks, one output bank, 1024x16
// - Host loads idle bank while core computes
// - Swap input bank roles at transform end (core swaps only in the triple arrangement)
// - Results go only to the output bank
// - Continuous input, one sample every 4 cycles
// - Results presented in digit-reversed order
// - Order bus gives natural-order write address
// - Result strobe frames exactly the valid samples
// - Host unloads output bank after write completes (this host never unloads; unload_request is tied low)
// - Host avoids output bank during result write
// - Mode sampled at start, then at mode strobe
// - Host may change mode at mode strobe
// - Bank select drives host input multiplexer
// - Core drives all input bank enables
// - Host fills first bank before starting
// - Start pulse lasts exactly one clock
// - Host holds unload request low
// - Triple arrangement: result every 4096 cycles
// - Load request pulse, then sample per clock
// - Mode inputs valid only at mode strobe
package fftpp_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned POINTS = 1024;
  localparam int unsigned AW = 10;
  localparam int unsigned DW = 16;
  localparam int unsigned DIGITS = 5;
  // ----------------------------------------------------------------
  // Timing in clock cycles
  // ----------------------------------------------------------------
  localparam logic [12:0] TRIPLE_PERIOD = 13'h1000;
  localparam logic [12:0] DUAL_PERIOD = 13'h1400;
  localparam logic [12:0] DUAL_FIRST_DONE = 13'h1030;
  localparam logic [12:0] RESULT_LEN = 13'h0400;
  localparam logic [12:0] MODE_SAMPLE_AT = 13'h0000;
  localparam logic [1:0] SAMPLE_SPACING = 2'h3;
  localparam logic [12:0] ONE = 13'h0001;
  localparam logic [AW-1:0] LAST_ADDR = 10'h3ff;
  // ----------------------------------------------------------------
  // Arrangements and states
  // ----------------------------------------------------------------
  typedef enum logic {TRIPLE, DUAL} fftpp_arr_t;
  typedef enum logic [1:0] {IDLE, LOAD, RUN} fftpp_state_t;
  typedef enum logic [1:0] {H_IDLE, H_FILL, H_STREAM} fftpp_hstate_t;

  // Digit reversal of a radix-4 index: result position to natural index
  function automatic logic [AW-1:0] digit_rev(input logic [AW-1:0] a);
    logic [AW-1:0] r;
    r = '0;
    for (int i = 0; i < DIGITS; i++) begin
      r[2*i +: 2] = a[2*(DIGITS-1-i) +: 2];
    end
    return r;
  endfunction
endpackage

/* File: tb/fft_pingpong_memory_control_test.sv */
// Bench of the ping-pong FFT controller: host end and core joined by the link.
// Assumes one 250 MHz clock; drives the host user side and the datapath feed.
`timescale 1ns/1ps
module fft_pingpong_memory_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  fftpp_pkg::fftpp_arr_t arr = fftpp_pkg::TRIPLE;
  logic go = 1'b0;
  logic u_dir = 1'b0;
  logic [1:0] u_scale = 2'h0;
  logic [fftpp_pkg::DW-1:0] u_re = 16'h0000, u_im = 16'h0000, r_re = 16'h0000, r_im = 16'h0000;
  logic cur_dir, prev_bank, exp_dir, chk_mode;
  logic [1:0] cur_scale, exp_scale;
  int n_errors = 0, num_checks = 0, cyc = 0, t_last = 0, n_done = 0;
  int gap_q[$];
  fftpp_if lnk ();
  fftpp_core fftpp_core_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .arrangement(arr),
    .result_in_re(r_re), .result_in_im(r_im), .cur_direction(cur_dir),
    .cur_scale(cur_scale), .lnk(lnk));
  fftpp_host fftpp_host_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .go(go),
    .user_direction(u_dir), .user_scale(u_scale), .user_re(u_re), .user_im(u_im),
    .sample_take(), .vector_ready(), .lnk(lnk));
  fftpp_monitor fftpp_monitor_inst (.clk(clk), .rst_n(rst_n), .start(lnk.start),
    .load_request(lnk.load_request), .unload_request(lnk.unload_request),
    .mode_sample(lnk.mode_sample), .result_valid(lnk.result_valid), .done(lnk.done),
    .bank_select(lnk.bank_select), .order_addr(lnk.order_addr),
    .first_bank_port_a_write_en(lnk.first_bank_port_a_write_en),
    .second_bank_port_a_write_en(lnk.second_bank_port_a_write_en));
  // Clock
  always #2 clk = ~clk;
  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic check_gap(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("ERROR %0t done gap %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic check_bits(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t value %b expected %b", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Random user samples, modes and datapath feed
  always @(posedge clk) begin
    u_re <= 16'($urandom);
    u_im <= 16'($urandom);
    r_re <= 16'($urandom);
    r_im <= 16'($urandom);
    u_dir <= 1'($urandom);
    u_scale <= 2'($urandom);
  end
  // Watcher: mode latch, done spacing, bank exchange, hang limit
  always @(negedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_errors++;
      stop_test();
    end else if (!rst_n) begin
      n_done = 0;
      chk_mode = 1'b0;
    end else begin
      if (chk_mode) begin
        check_bits({1'b0, cur_dir}, {1'b0, exp_dir});
        check_bits(cur_scale, exp_scale);
      end
      chk_mode = lnk.start || lnk.mode_sample;
      exp_dir = lnk.transform_direction;
      exp_scale = lnk.scale_select;
      // Start is taken at the next rising edge
      if (lnk.start) t_last = cyc + 1;
      if (lnk.done) begin
        check_gap(cyc - t_last, gap_q.size() > 0 ? gap_q.pop_front() : -1);
        if (n_done > 0) check_bits({1'b0, lnk.bank_select},
          {1'b0, (arr == fftpp_pkg::TRIPLE) ? ~prev_bank : prev_bank});
        prev_bank = lnk.bank_select;
        t_last = cyc;
        n_done++;
      end
    end
  end
  // One fill, start and n back-to-back transforms
  task automatic run(input int n);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (arr == fftpp_pkg::TRIPLE) gap_q.push_back(4096);
      else gap_q.push_back(i == 0 ? 4144 : 5120);
    end
    while (n_done < n) @(posedge clk);
  endtask
  // ----------------------------------------
  // Main sequence: triple run, reset, dual run
  // ----------------------------------------
  initial begin
    void'($urandom(21));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    run(3);
    rst_n <= 1'b0;
    arr <= fftpp_pkg::DUAL;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    run(3);
    stop_test();
  end
endmodule

/* File: tb/fftpp_monitor.sv */
// Checker of the host-core link of the ping-pong FFT controller.
// Assumes it sits beside the link interface, sampling on clk with rst_n.
`timescale 1ns/1ps
module fftpp_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host to core
  input wire logic start,
  input wire logic load_request,
  input wire logic unload_request,
  // Core to host
  input wire logic mode_sample,
  input wire logic result_valid,
  input wire logic done,
  input wire logic bank_select,
  input wire logic [fftpp_pkg::AW-1:0] order_addr,
  input wire logic first_bank_port_a_write_en,
  input wire logic second_bank_port_a_write_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [10:0] vcnt;
  logic [9:0] p;
  // ----------------------------------------
  // Position within the result burst
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vcnt <= 11'h000;
    end else begin
      vcnt <= result_valid ? vcnt + 11'h001 : 11'h000;
    end
  end
  // Low position bits for the radix-4 reversal
  assign p = vcnt[9:0];
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  start_one_clk_a: assert property (start |=> !start) else $error("start too long");
  load_one_clk_a: assert property (load_request |=> !load_request)
    else $error("load request too long");
  unload_low_a: assert property (!unload_request) else $error("unload request raised");
  burst_len_a: assert property ($fell(result_valid) |-> vcnt == 11'h400)
    else $error("result burst not 1024 long");
  burst_max_a: assert property (result_valid |-> vcnt < 11'h400)
    else $error("result burst too long");
  order_rev_a: assert property (result_valid |->
    order_addr == {p[1:0], p[3:2], p[5:4], p[7:6], p[9:8]}) else $error("order address wrong");
  done_after_a: assert property ($fell(result_valid) |-> done)
    else $error("done missing after burst");
  done_pulse_a: assert property (done |=> !done) else $error("done too long");
  bank_hold_a: assert property (result_valid && $past(result_valid) |->
    $stable(bank_select)) else $error("bank moved in burst");
  one_bank_a: assert property (!(first_bank_port_a_write_en &&
    second_bank_port_a_write_en)) else $error("both banks written");
  mode_pulse_a: assert property (mode_sample |=> !mode_sample)
    else $error("mode strobe too long");
  // Main scenarios
  cover property ($fell(result_valid));
  cover property (mode_sample);
  cover property (start);
  cover property (bank_select ##1 !bank_select);
endmodule
